// ### rtl/imre_pkg.sv
/*
  Constants for the input monitor and relay enable block: register map,
  field positions, reset values and sample timing.
  Assumes a single 10 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// How it works
// - The live state of the eight digital inputs is readable at any time.
// - Qualified transitions latch in a change register that clears when read.
// - Per-bit rise and fall masks select which transitions latch.
// - Inputs are sampled for edges at more than one kilohertz.
// - Per-bit enables gate change bits into a summary bit of the status byte.
// - A newly set enabled change bit issues a service request.
// - Relay outputs stay off until saved setup is loaded and self-test is done.
// - A relay enable output goes active only once the outputs are enabled.
// - Sixteen output channels each follow their own latch bit.
// - A service request needs a mask-matching edge on an enabled input.
package imre_pkg;
  localparam int ADDR_W = 8;
  localparam int IN_W = 8;
  localparam int OUT_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_LEVEL = 8'h00;
  localparam logic [7:0] OFS_CHANGE = 8'h04;
  localparam logic [7:0] OFS_CHG_EN = 8'h08;
  localparam logic [7:0] OFS_RISE = 8'h0C;
  localparam logic [7:0] OFS_FALL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RELAY = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  // field positions
  localparam int STAT_SUM_BIT = 3;
  localparam int STAT_SRQ_BIT = 6;
  localparam int CTRL_LOADED_BIT = 0;
  localparam int CTRL_SELFTEST_BIT = 1;
  localparam int CTRL_OUT_EN_BIT = 2;
  localparam int IRQ_CHANGE_BIT = 0;
  localparam int IRQ_OUT_EN_BIT = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_RELAY = 16'h0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_NS = 100_000;
  localparam int SAMPLE_CYC = (SAMPLE_NS / 100 > 0) ? SAMPLE_NS / (1_000_000_000 / CLK_HZ) : 1;
  localparam int CNT_W = $clog2(SAMPLE_CYC + 1);
endpackage

// ### rtl/imre_sync.sv
/*
  Two-stage synchroniser for a bus of independent level inputs.
  Assumes each bit is sampled on its own; no bus coherence is implied.
*/
`timescale 1ns/1ps
module imre_sync #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ### rtl/imre_edge.sv
/*
  Sampled edge detector with per-bit rise and fall masks.
  Assumes data_in is already synchronous and sample_tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
module imre_edge #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_tick,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic [WIDTH-1:0] rise_filter_mask,
  input wire logic [WIDTH-1:0] fall_filter_mask,
  output logic [WIDTH-1:0] hits
);
  logic [WIDTH-1:0] prev_q;

  // previous sample only moves on a tick so edges are seen at the sample rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= '0;
    end else if (sample_tick) begin
      prev_q <= data_in;
    end
  end

  always_comb begin
    hits = '0;
    if (sample_tick) begin
      hits = (~prev_q & data_in & rise_filter_mask) | (prev_q & ~data_in & fall_filter_mask);
    end
  end
endmodule

// ### rtl/imre_top.sv
/*
  Input monitor and relay enable block with an AXI4-Lite register slave,
  sticky interrupt status, mask and one level interrupt.
  Assumes digital inputs are asynchronous and the host loads the relay latch
  and flags loading and self-test completion through the control register.
*/
`timescale 1ns/1ps
module imre_top
  import imre_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic [2:0] s_axil_awprot,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic [2:0] s_axil_arprot,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [IN_W-1:0] digital_in,
  output logic [OUT_W-1:0] relay_out,
  output logic relay_enable,
  output logic service_req,
  output logic irq
);
  logic [IN_W-1:0] level_q;
  logic [IN_W-1:0] hits;
  logic [IN_W-1:0] chg_q, chg_d;
  logic [IN_W-1:0] chg_en_q, rise_q, fall_q;
  logic [OUT_W-1:0] latch_q;
  logic loaded_q, selftest_q, out_en_q;
  logic srq_d, srq_q, summary;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic [CNT_W-1:0] cnt_q;
  logic tick;
  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_hs, w_hs, ar_hs, do_wr, rd_clr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_IRQ_MASK);
  endfunction

  imre_sync #(.WIDTH(IN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(digital_in),
    .sync_out(level_q)
  );

  // a free-running divider; 100 us gives a 10 kHz sample rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (cnt_q == CNT_W'(SAMPLE_CYCLES - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
  assign tick = (cnt_q == CNT_W'(SAMPLE_CYCLES - 1));

  imre_edge #(.WIDTH(IN_W)) u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_tick(tick),
    .data_in(level_q),
    .rise_filter_mask(rise_q),
    .fall_filter_mask(fall_q),
    .hits(hits)
  );

  // bus handshakes: one write and one read in flight
  assign s_axil_awready = !aw_full_q && !s_axil_bvalid;
  assign s_axil_wready = !w_full_q && !s_axil_bvalid;
  assign s_axil_arready = !s_axil_rvalid;
  assign aw_hs = s_axil_awvalid && s_axil_awready;
  assign w_hs = s_axil_wvalid && s_axil_wready;
  assign ar_hs = s_axil_arvalid && s_axil_arready;
  assign do_wr = aw_full_q && w_full_q && !s_axil_bvalid;
  assign rd_clr = ar_hs && (s_axil_araddr == OFS_CHANGE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axil_awaddr;
      end
      if (w_hs) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axil_wdata;
        wstrb_q <= s_axil_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; masks and enables start clear so nothing fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_en_q <= RST_BYTE;
      rise_q <= RST_BYTE;
      fall_q <= RST_BYTE;
      latch_q <= RST_RELAY;
      irq_mask_q <= RST_IRQ;
    end else if (do_wr) begin
      unique case (awaddr_q)
        OFS_CHG_EN: chg_en_q <= IN_W'(merge({24'h0, chg_en_q}, wdata_q, wstrb_q));
        OFS_RISE: rise_q <= IN_W'(merge({24'h0, rise_q}, wdata_q, wstrb_q));
        OFS_FALL: fall_q <= IN_W'(merge({24'h0, fall_q}, wdata_q, wstrb_q));
        OFS_RELAY: latch_q <= OUT_W'(merge({16'h0, latch_q}, wdata_q, wstrb_q));
        OFS_IRQ_MASK: irq_mask_q <= IRQ_W'(merge({30'h0, irq_mask_q}, wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  // loading and self-test flags are one-way: only reset withdraws the outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loaded_q <= 1'b0;
      selftest_q <= 1'b0;
      out_en_q <= 1'b0;
    end else begin
      if (do_wr && awaddr_q == OFS_CTRL && wstrb_q[0]) begin
        if (wdata_q[CTRL_LOADED_BIT]) begin
          loaded_q <= 1'b1;
        end
        if (wdata_q[CTRL_SELFTEST_BIT]) begin
          selftest_q <= 1'b1;
        end
      end
      out_en_q <= loaded_q && selftest_q;
    end
  end

  // outputs are forced off until enabled so a half-loaded latch never shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_out <= RST_RELAY;
      relay_enable <= 1'b0;
    end else begin
      relay_out <= out_en_q ? latch_q : RST_RELAY;
      relay_enable <= out_en_q;
    end
  end

  // a new edge wins over the clear-on-read in the same cycle
  always_comb begin
    chg_d = (rd_clr ? RST_BYTE : chg_q) | hits;
    srq_d = |(hits & chg_en_q & ~chg_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_q <= RST_BYTE;
      srq_q <= 1'b0;
    end else begin
      chg_q <= chg_d;
      srq_q <= srq_d;
    end
  end
  assign service_req = srq_q;
  assign summary = |(chg_q & chg_en_q);

  assign irq_set = {out_en_q && !relay_enable, srq_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= RST_IRQ;
    end else begin
      // set beats write-one-to-clear
      irq_stat_q <= (do_wr && awaddr_q == OFS_IRQ_STAT && wstrb_q[0])
                    ? ((irq_stat_q & ~wdata_q[IRQ_W-1:0]) | irq_set)
                    : (irq_stat_q | irq_set);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read path: data captured at the address handshake, valid next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rresp <= mapped(s_axil_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axil_araddr)
        OFS_LEVEL: s_axil_rdata <= {24'h0, level_q};
        OFS_CHANGE: s_axil_rdata <= {24'h0, chg_q};
        OFS_CHG_EN: s_axil_rdata <= {24'h0, chg_en_q};
        OFS_RISE: s_axil_rdata <= {24'h0, rise_q};
        OFS_FALL: s_axil_rdata <= {24'h0, fall_q};
        OFS_STATUS: s_axil_rdata <= 32'(summary) << STAT_SUM_BIT
                                    | 32'(srq_q) << STAT_SRQ_BIT;
        OFS_RELAY: s_axil_rdata <= {16'h0, latch_q};
        OFS_CTRL: s_axil_rdata <= 32'(loaded_q) << CTRL_LOADED_BIT
                                  | 32'(selftest_q) << CTRL_SELFTEST_BIT
                                  | 32'(out_en_q) << CTRL_OUT_EN_BIT;
        OFS_IRQ_STAT: s_axil_rdata <= {30'h0, irq_stat_q};
        OFS_IRQ_MASK: s_axil_rdata <= {30'h0, irq_mask_q};
        default: s_axil_rdata <= 32'h00000000;
      endcase
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_change_clears:
    assert property ((rd_clr && hits == 8'h00) |=> chg_q == 8'h00)
      else $error("change register not cleared by read");
  a_change_sticky:
    assert property (!rd_clr |=> (chg_q & $past(chg_q)) == $past(chg_q))
      else $error("change bit lost without a read");
  a_tick_spacing:
    assert property (tick |=> !tick [*8])
      else $error("sample tick too frequent");
  a_hits_on_tick:
    assert property (hits != 8'h00 |-> tick && ((hits & ~(rise_q | fall_q)) == 8'h00))
      else $error("edge seen off tick or outside masks");
  a_summary_bit:
    assert property ((ar_hs && s_axil_araddr == OFS_STATUS)
      |=> s_axil_rdata[STAT_SUM_BIT] == $past(|(chg_q & chg_en_q)))
      else $error("summary bit disagrees with change and enable");
  a_srq_cause:
    assert property (service_req |-> $past(|(hits & chg_en_q)))
      else $error("service request without enabled edge");
  a_outputs_held:
    assert property (!$past(out_en_q) |-> relay_out == 16'h0000 && !relay_enable)
      else $error("outputs active before enable");
  a_enable_cause:
    assert property ($rose(relay_enable) |-> $past(loaded_q && selftest_q, 2))
      else $error("relay enable without load and self-test");
  a_relay_follow:
    assert property (out_en_q |=> relay_out == $past(latch_q))
      else $error("relay output does not follow latch");
  a_reset_clear:
    assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> chg_q == 8'h00 && chg_en_q == 8'h00 && rise_q == 8'h00 && fall_q == 8'h00)
      else $error("monitor state not clear after reset");

  c_service_req: cover property (service_req);
  c_change_read: cover property (rd_clr && chg_q != 8'h00);
  c_outputs_on: cover property ($rose(relay_enable));
endmodule

// ### dv/imre_host.sv
/*
  Host application model: an AXI4-Lite master that issues one access at a time.
  Assumes the slave answers by itself; only the bench watchdog ends a wait.
*/
`timescale 1ns/1ps
module imre_host (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // address and data go out together; each drops only once its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        d = rdata;
        resp = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask
endmodule

// ### dv/testbench.sv
/*
  Self-checking bench for the input monitor and relay enable block.
  Assumes the block's own assertions run alongside; sample period is shortened.
*/
`timescale 1ns/1ps
module testbench;
  import imre_pkg::*;
  localparam int SP = 10;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] resp; logic [31:0] e;}
    imre_row_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [IN_W-1:0] din = 8'h02;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [OUT_W-1:0] relay_out;
  logic relay_enable, service_req, irq;
  int num_errors = 0;
  int num_checks = 0;
  int srq_cnt = 0;
  imre_row_t rows [12];

  always #50 aclk = ~aclk;
  always @(posedge aclk) if (service_req === 1'h1) srq_cnt <= srq_cnt + 1;

  imre_top #(.SAMPLE_CYCLES(SP)) i_imre_top (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awprot(3'h0), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arprot(3'h0), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .digital_in(din), .relay_out(relay_out),
    .relay_enable(relay_enable), .service_req(service_req), .irq(irq));

  imre_host i_imre_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_imre_host.wr(a, d, rs);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    i_imre_host.rd(a, rd, rs);
    chk(rd & m, e);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // sized from the scenario length with a wide margin
  initial begin
    wt(20000);
    num_errors++;
    end_of_test;
  end

  initial begin
    rows[0] = '{1'h0, OFS_CHANGE, 32'h0, RESP_OKAY, 32'h0};
    rows[1] = '{1'h0, OFS_CHG_EN, 32'h0, RESP_OKAY, 32'h0};
    rows[2] = '{1'h0, OFS_RISE, 32'h0, RESP_OKAY, 32'h0};
    rows[3] = '{1'h0, OFS_FALL, 32'h0, RESP_OKAY, 32'h0};
    rows[4] = '{1'h0, OFS_RELAY, 32'h0, RESP_OKAY, 32'h0};
    rows[5] = '{1'h0, OFS_IRQ_MASK, 32'h0, RESP_OKAY, 32'h0};
    rows[6] = '{1'h0, OFS_IRQ_STAT, 32'h0, RESP_OKAY, 32'h0};
    rows[7] = '{1'h1, OFS_RISE, 32'h1FF, RESP_OKAY, 32'h0};
    rows[8] = '{1'h0, OFS_RISE, 32'h0, RESP_OKAY, 32'hFF};
    rows[9] = '{1'h0, 8'h28, 32'h0, RESP_SLVERR, 32'h0};
    rows[10] = '{1'h1, 8'h28, 32'h5, RESP_SLVERR, 32'h0};
    rows[11] = '{1'h0, 8'h06, 32'h0, RESP_SLVERR, 32'h0};
    wt(5);
    aresetn <= 1'h1;
    wt(1);
    chk({15'h0, relay_enable, relay_out}, 32'h0);
    chk({30'h0, service_req, irq}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) i_imre_host.wr(rows[i].a, rows[i].d, rs);
      else i_imre_host.rd(rows[i].a, rd, rs);
      chk({30'h0, rs}, {30'h0, rows[i].resp});
      if (!rows[i].wr) chk(rd, rows[i].e);
    end
    w(OFS_RISE, 32'h01);
    w(OFS_FALL, 32'h02);
    w(OFS_CHG_EN, 32'h03);
    w(OFS_IRQ_MASK, 32'h01);
    rc(OFS_LEVEL, 32'hFF, 32'h02);
    rc(OFS_CHANGE, 32'hFF, 32'h00);
    // a qualified fall must be seen within one sample period plus the synchroniser
    din <= 8'h00;
    wt(SP + 5);
    chk(srq_cnt, 1);
    chk({31'h0, irq}, 32'h1);
    rc(OFS_STATUS, 32'h1 << STAT_SUM_BIT, 32'h1 << STAT_SUM_BIT);
    rc(OFS_LEVEL, 32'hFF, 32'h00);
    rc(OFS_CHANGE, 32'hFF, 32'h02);
    rc(OFS_CHANGE, 32'hFF, 32'h00);
    rc(OFS_STATUS, 32'h1 << STAT_SUM_BIT, 32'h0);
    rc(OFS_IRQ_STAT, 32'h1, 32'h1);
    w(OFS_IRQ_STAT, 32'h1);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    // rise on a bit whose rise mask is off
    din <= 8'h02;
    wt(SP + 5);
    chk(srq_cnt, 1);
    rc(OFS_CHANGE, 32'hFF, 32'h00);
    // masked edge on a bit whose enable is off
    w(OFS_RISE, 32'h05);
    w(OFS_IRQ_MASK, 32'h0);
    din <= 8'h06;
    wt(SP + 5);
    chk(srq_cnt, 1);
    din <= 8'h07;
    wt(SP + 5);
    chk(srq_cnt, 2);
    chk({31'h0, irq}, 32'h0);
    // bit 2 latches although its enable is off; only bit 0 raised the request
    rc(OFS_CHANGE, 32'h7, 32'h5);
    rc(OFS_IRQ_STAT, 32'h1, 32'h1);
    // outputs stay off until both loading and self-test are flagged
    w(OFS_RELAY, 32'hBEEF);
    w(OFS_CTRL, 32'h1 << CTRL_LOADED_BIT);
    wt(3);
    chk({15'h0, relay_enable, relay_out}, 32'h0);
    w(OFS_CTRL, 32'h1 << CTRL_SELFTEST_BIT);
    wt(3);
    chk({15'h0, relay_enable, relay_out}, 32'h1BEEF);
    rc(OFS_CTRL, 32'h1 << CTRL_OUT_EN_BIT, 32'h1 << CTRL_OUT_EN_BIT);
    rc(OFS_IRQ_STAT, 32'h1 << IRQ_OUT_EN_BIT, 32'h1 << IRQ_OUT_EN_BIT);
    w(OFS_RELAY, 32'h8001);
    wt(3);
    chk({16'h0, relay_out}, 32'h8001);
    // second reset mid-run
    aresetn <= 1'h0;
    wt(5);
    aresetn <= 1'h1;
    wt(1);
    chk({15'h0, relay_enable, relay_out}, 32'h0);
    rc(OFS_CHG_EN, 32'hFF, 32'h0);
    rc(OFS_RISE, 32'hFF, 32'h0);
    end_of_test;
  end
endmodule
